// ### tlx_regs.svh
// Offsets, field positions, reset values and counts for the trigger line crosspoint.
`ifndef TLX_REGS_SVH
`define TLX_REGS_SVH

`define TLX_PATTERN_BITS        56
`define TLX_HALF_BITS           28
`define TLX_PIN_COUNT           7
`define TLX_FIELD_BITS          4
`define TLX_FIELD_OE_BIT        0
`define TLX_FIELD_SEL_LSB       1
`define TLX_FIELD_SEL_MSB       3
`define TLX_SHIFT_DATA_BIT      0
`define TLX_LOAD_VALUE          8'h00
`define TLX_PATTERN_RESET       56'h00000000000000
`define TLX_LAST_BIT_INDEX      6'h37
`define TLX_FULL_COUNT          6'h38

`define TLX_OFF_PATTERN_LO      8'h00
`define TLX_OFF_PATTERN_HI      8'h04
`define TLX_OFF_CONTROL         8'h08
`define TLX_OFF_STATUS          8'h0c

`define TLX_CONTROL_START_BIT   0
`define TLX_STATUS_BUSY_BIT     0
`define TLX_STATUS_DONE_BIT     1
`define TLX_STATUS_COUNT_LSB    8
`define TLX_STATUS_COUNT_MSB    13
`define TLX_STATUS_LIVE_BIT     16
`define TLX_STATUS_CONFLICT_BIT 17
`define TLX_PATTERN_HI_BITS     24

`endif

// ### tlx_pkg.sv
// Types shared by both ends of the trigger line crosspoint.
package tlx_pkg;

    typedef logic [55:0] tlx_pattern_t;

    typedef enum logic
    {
        TLX_SEL_SHIFT = 1'b0,
        TLX_SEL_LOAD  = 1'b1
    } tlx_reg_sel_t;

    typedef enum logic [1:0]
    {
        TLX_ST_IDLE  = 2'b00,
        TLX_ST_SHIFT = 2'b01,
        TLX_ST_LOAD  = 2'b10
    } tlx_state_t;

endpackage

// ### tlx_if.sv
// Configuration link between the crosspoint controller and the crosspoint switch.
`timescale 1ns/1ps

interface tlx_if;
    logic                 wr_stb;
    tlx_pkg::tlx_reg_sel_t wr_sel;
    logic [7:0]           wr_data;
    logic [5:0]           bit_count;
    logic                 routing_live;
    logic                 board_conflict;

    modport device
    (
        input  wr_stb,
        input  wr_sel,
        input  wr_data,
        output bit_count,
        output routing_live,
        output board_conflict
    );

    modport host
    (
        output wr_stb,
        output wr_sel,
        output wr_data,
        input  bit_count,
        input  routing_live,
        input  board_conflict
    );
endinterface

// ### tlx_pin_cell.sv
// One crosspoint pin: decodes a 4-bit control field and drives the pin from its source.
`timescale 1ns/1ps
`include "tlx_regs.svh"

module tlx_pin_cell
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    input  wire logic [3:0] field,
    input  wire logic [6:0] sources,
    output logic            pin_out,
    output logic            pin_oe
);

    wire logic [2:0] source_pin_select;
    wire logic       pin_drive_enable;
    wire logic [7:0] source_ext;
    wire logic       next_pin_out;

    assign source_pin_select = field[`TLX_FIELD_SEL_MSB:`TLX_FIELD_SEL_LSB];
    assign pin_drive_enable  = field[`TLX_FIELD_OE_BIT];
    // Code 7 names no pin, so it selects a constant low.
    assign source_ext        = {1'b0, sources};
    assign next_pin_out      = pin_drive_enable & source_ext[source_pin_select];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_out <= next_pin_out;
            pin_oe  <= pin_drive_enable;
        end
    end

endmodule // tlx_pin_cell

// ### tlx_switch.sv
// Crosspoint switch end: serial pattern capture, strobe load and fourteen routed pins.
`timescale 1ns/1ps
`include "tlx_regs.svh"

// Operation
// - Seven board-side pins, seven trigger-line pins.
// - Any board pin routes to any line; lines drive only board pins 1, 2 and 6.
// - 56-bit pattern shifted serially, loaded by strobe.
// - Shift write keeps only data bit 0.
// - Low 28 bits: line pins; high 28: board pins.
// - Each half: seven 4-bit fields, one per pin.
// - Three-bit select names opposite-side source pin number.
// - Enable set drives pin; clear leaves it undriven.
// - Field bit 0 enables; bits 3..1 select source.
// - Host shifts bits 0 to 55, one write each.
// - Host shift writes are bytes, bit in bit 0.
// - Byte zero to load register applies new routing.
// - Host clears enable for inputs and unused pins.
// - Board pins 0..3: timer1, gate, none, update strobe.
// - Board pins 4,5 timers 3,2; pin 6 refresh both ways.
// - Line pins 0..6 map to trigger lines, bidirectional.
module tlx_switch
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    tlx_if.device           cfg,
    input  wire logic       timer1_pulse_n,
    input  wire logic       internal_update_strobe_n,
    input  wire logic       timer3_pulse_n,
    input  wire logic       timer2_pulse_n,
    output logic            counter_gate_input,
    input  wire logic       external_refresh_line_n_in,
    output logic            external_refresh_line_n_out,
    output logic            external_refresh_line_n_oe,
    input  wire logic [6:0] shared_trigger_line_in,
    output logic      [6:0] shared_trigger_line_out,
    output logic      [6:0] shared_trigger_line_oe
);

    tlx_pkg::tlx_pattern_t shift_pattern;
    tlx_pkg::tlx_pattern_t active_pattern;
    logic [5:0]            bit_count;
    logic                  routing_live;
    logic                  board_conflict;

    wire logic                  shift_write;
    wire logic                  load_write;
    wire logic                  shift_bit;
    wire tlx_pkg::tlx_pattern_t next_shift_pattern;
    wire logic [5:0]            next_bit_count;

    wire logic [6:0]  board_level;
    wire logic [6:0]  line_level;
    wire logic [6:0]  board_out;
    wire logic [6:0]  board_oe;
    wire logic [6:0]  line_out;
    wire logic [6:0]  line_oe;
    wire logic [6:0]  board_fixed_mask;
    wire logic        next_board_conflict;

    // Configuration writes are decoded from the link strobe and register select.
    assign shift_write = cfg.wr_stb & (cfg.wr_sel == tlx_pkg::TLX_SEL_SHIFT);
    assign load_write  = cfg.wr_stb & (cfg.wr_sel == tlx_pkg::TLX_SEL_LOAD);

    // Only the lowest data bit is captured; the upper seven bits are ignored.
    assign shift_bit = cfg.wr_data[`TLX_SHIFT_DATA_BIT];

    // Bits enter at the top and move down, so the first bit written ends at bit 0
    // once the host has made all 56 writes in ascending order.
    assign next_shift_pattern = {shift_bit, shift_pattern[`TLX_PATTERN_BITS-1:1]};

    // The count saturates at a full pattern and restarts on each load.
    assign next_bit_count = (bit_count == `TLX_FULL_COUNT) ? bit_count : bit_count + 6'h01;

    // Every register here moves only at an edge with the clock enable high.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_pattern <= `TLX_PATTERN_RESET;
        end
        else if (clk_en && shift_write)
        begin
            shift_pattern <= next_shift_pattern;
        end
    end

    // The load register takes the whole shifted pattern whatever byte is written;
    // the host always writes zero there.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_pattern <= `TLX_PATTERN_RESET;
        end
        else if (clk_en && load_write)
        begin
            active_pattern <= shift_pattern;
        end
    end

    // The count lets the controller see that a whole pattern went in before the load.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_count <= 6'h00;
        end
        else if (clk_en && load_write)
        begin
            bit_count <= 6'h00;
        end
        else if (clk_en && shift_write)
        begin
            bit_count <= next_bit_count;
        end
    end

    // Live stays set until reset; later loads only change the routing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            routing_live <= 1'b0;
        end
        else if (clk_en && load_write)
        begin
            routing_live <= 1'b1;
        end
    end

    // Levels seen on the board-side pins. Pins 1 and 2 have no board driver, so
    // their level is whatever the switch itself drives there.
    assign board_level[0] = timer1_pulse_n;
    assign board_level[1] = board_out[1];
    assign board_level[2] = board_out[2];
    assign board_level[3] = internal_update_strobe_n;
    assign board_level[4] = timer3_pulse_n;
    assign board_level[5] = timer2_pulse_n;
    assign board_level[6] = external_refresh_line_n_in;

    // Trigger line pins receive from the shared lines.
    assign line_level = shared_trigger_line_in;

    // Line-side fields sit in the low half, board-side fields in the high half.
    // All pin outputs are registered, so no combinational loop can form through
    // two pins that select each other.
    genvar pin;
    generate
        for (pin = 0; pin < `TLX_PIN_COUNT; pin = pin + 1)
        begin : g_pin
            tlx_pin_cell u_line_pin
            (
                .pclk    (pclk),
                .presetn (presetn),
                .clk_en  (clk_en),
                .field   (active_pattern[pin*`TLX_FIELD_BITS +: `TLX_FIELD_BITS]),
                .sources (board_level),
                .pin_out (line_out[pin]),
                .pin_oe  (line_oe[pin])
            );

            tlx_pin_cell u_board_pin
            (
                .pclk    (pclk),
                .presetn (presetn),
                .clk_en  (clk_en),
                .field   (active_pattern[`TLX_HALF_BITS + pin*`TLX_FIELD_BITS +: `TLX_FIELD_BITS]),
                .sources (line_level),
                .pin_out (board_out[pin]),
                .pin_oe  (board_oe[pin])
            );
        end
    endgenerate

    // Board pins 0, 3, 4 and 5 are driven by board logic and cannot take a drive
    // from the switch; enabling one of them is reported instead of applied.
    assign board_fixed_mask    = 7'h39;
    assign next_board_conflict = |(board_oe & board_fixed_mask);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            board_conflict <= 1'b0;
        end
        else if (clk_en)
        begin
            board_conflict <= next_board_conflict;
        end
    end

    // Board pin 2 has no signal behind it, so a drive routed there reaches only line pins that select it.
    assign counter_gate_input          = board_out[1];
    assign external_refresh_line_n_out = board_out[6];
    assign external_refresh_line_n_oe  = board_oe[6];
    assign shared_trigger_line_out     = line_out;
    assign shared_trigger_line_oe      = line_oe;

    // Count and flags go back to the controller for its status register.
    assign cfg.bit_count      = bit_count;
    assign cfg.routing_live   = routing_live;
    assign cfg.board_conflict = board_conflict;

endmodule // tlx_switch

// ### tlx_host.sv
// Crosspoint controller end: APB registers and the serial shift-and-load sequencer.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "tlx_regs.svh"

module tlx_host
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    tlx_if.host              cfg
);

    logic [31:0]           pattern_lo;
    logic [23:0]           pattern_hi;
    logic                  ready;
    logic                  done;
    tlx_pkg::tlx_state_t   state;
    tlx_pkg::tlx_pattern_t shadow;
    logic [5:0]            bit_index;
    logic                  wr_stb;
    tlx_pkg::tlx_reg_sel_t wr_sel;
    logic [7:0]            wr_data;

    wire logic        access;
    wire logic        sel_lo;
    wire logic        sel_hi;
    wire logic        sel_ctrl;
    wire logic        sel_stat;
    wire logic        mapped;
    wire logic        wr_done;
    wire logic        start;
    wire logic        busy;
    wire logic [31:0] status_word;
    wire logic [31:0] read_mux;

    assign access   = psel & penable;
    assign sel_lo   = (paddr == `TLX_OFF_PATTERN_LO);
    assign sel_hi   = (paddr == `TLX_OFF_PATTERN_HI);
    assign sel_ctrl = (paddr == `TLX_OFF_CONTROL);
    assign sel_stat = (paddr == `TLX_OFF_STATUS);
    assign mapped   = sel_lo | sel_hi | sel_ctrl | sel_stat;
    assign wr_done  = access & ready & pwrite & mapped;
    assign busy     = (state != tlx_pkg::TLX_ST_IDLE);
    // A start while a sequence runs is ignored.
    assign start    = wr_done & sel_ctrl & pwdata[`TLX_CONTROL_START_BIT] & ~busy;

    assign status_word = {14'h0000, cfg.board_conflict, cfg.routing_live, 2'h0, cfg.bit_count,
                          6'h00, done, busy};

    assign read_mux = sel_lo   ? pattern_lo :
                      sel_hi   ? {8'h00, pattern_hi} :
                      sel_stat ? status_word : 32'h00000000;

    // Every access waits one cycle: read data is registered in the first access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ready  <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (clk_en)
        begin
            ready  <= access & ~ready;
            prdata <= read_mux;
        end
    end

    assign pready  = ready;
    assign pslverr = ready & ~mapped;

    // Software composes the pattern, with drive enables clear for inputs and unused pins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pattern_lo <= 32'h00000000;
            pattern_hi <= 24'h000000;
        end
        else if (clk_en && wr_done && sel_lo)
        begin
            pattern_lo <= pwdata;
        end
        else if (clk_en && wr_done && sel_hi)
        begin
            pattern_hi <= pwdata[`TLX_PATTERN_HI_BITS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state     <= tlx_pkg::TLX_ST_IDLE;
            shadow    <= `TLX_PATTERN_RESET;
            bit_index <= 6'h00;
        end
        else if (clk_en)
        begin
            case (state)
                tlx_pkg::TLX_ST_IDLE:
                begin
                    if (start)
                    begin
                        shadow    <= {pattern_hi, pattern_lo};
                        bit_index <= 6'h00;
                        state     <= tlx_pkg::TLX_ST_SHIFT;
                    end
                end
                tlx_pkg::TLX_ST_SHIFT:
                begin
                    shadow    <= shadow >> 1;
                    bit_index <= bit_index + 6'h01;
                    if (bit_index == `TLX_LAST_BIT_INDEX)
                    begin
                        state <= tlx_pkg::TLX_ST_LOAD;
                    end
                end
                default:
                begin
                    state <= tlx_pkg::TLX_ST_IDLE;
                end
            endcase
        end
    end

    // One byte write per pattern bit, lowest bit first, then the zero load write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_stb  <= 1'b0;
            wr_sel  <= tlx_pkg::TLX_SEL_SHIFT;
            wr_data <= 8'h00;
        end
        else if (clk_en)
        begin
            wr_stb  <= (state == tlx_pkg::TLX_ST_SHIFT) | (state == tlx_pkg::TLX_ST_LOAD);
            wr_sel  <= (state == tlx_pkg::TLX_ST_LOAD) ? tlx_pkg::TLX_SEL_LOAD : tlx_pkg::TLX_SEL_SHIFT;
            wr_data <= (state == tlx_pkg::TLX_ST_SHIFT) ? {7'h00, shadow[0]} : `TLX_LOAD_VALUE;
        end
    end

    // Done is cleared only by a new start, which cannot coincide with a finish.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done <= 1'b0;
        end
        else if (clk_en && state == tlx_pkg::TLX_ST_LOAD)
        begin
            done <= 1'b1;
        end
        else if (clk_en && start)
        begin
            done <= 1'b0;
        end
    end

    assign cfg.wr_stb  = wr_stb;
    assign cfg.wr_sel  = wr_sel;
    assign cfg.wr_data = wr_data;

endmodule // tlx_host

// ### tlx_checker.sv
// Assertion checker watching the configuration link between the two crosspoint ends.
`timescale 1ns/1ps

module tlx_checker
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  clk_en,
    input wire logic                  wr_stb,
    input wire tlx_pkg::tlx_reg_sel_t wr_sel,
    input wire logic [7:0]            wr_data,
    input wire logic [5:0]            bit_count,
    input wire logic                  routing_live,
    input wire logic                  board_conflict
);
    wire logic shift_wr;
    wire logic load_wr;

    assign shift_wr = clk_en && wr_stb && (wr_sel == tlx_pkg::TLX_SEL_SHIFT);
    assign load_wr  = clk_en && wr_stb && (wr_sel == tlx_pkg::TLX_SEL_LOAD);

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_reset_quiet;
        $rose(presetn) |-> (bit_count == 6'h00) && !routing_live && !board_conflict && !wr_stb;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("link not quiet after reset");

    property p_count_step;
        shift_wr && (bit_count < 6'h38) |=> bit_count == $past(bit_count) + 6'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("shift write not counted");

    property p_count_hold;
        clk_en && !wr_stb |=> $stable(bit_count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved without a write");

    property p_load_after_full;
        load_wr |-> bit_count == 6'h38;
    endproperty
    a_load_after_full: assert property (p_load_after_full) else $error("load before all bits shifted");

    property p_load_byte;
        load_wr |-> wr_data == 8'h00;
    endproperty
    a_load_byte: assert property (p_load_byte) else $error("load byte not zero");

    property p_shift_byte;
        shift_wr |-> wr_data[7:1] == 7'h00;
    endproperty
    a_shift_byte: assert property (p_shift_byte) else $error("shift byte carries upper bits");

    property p_load_effect;
        load_wr |=> routing_live && (bit_count == 6'h00) && !wr_stb;
    endproperty
    a_load_effect: assert property (p_load_effect) else $error("load write had no effect");

    property p_live_holds;
        routing_live |=> routing_live;
    endproperty
    a_live_holds: assert property (p_live_holds) else $error("routing live dropped");

    property p_count_limit;
        bit_count <= 6'h38;
    endproperty
    a_count_limit: assert property (p_count_limit) else $error("count above pattern length");
endmodule // tlx_checker

// ### test_trigger_line_crosspoint.sv
// Self-checking testbench joining the crosspoint controller and switch over their link.
`timescale 1ns/1ps
`include "tlx_regs.svh"

module test_trigger_line_crosspoint;
    typedef struct packed
    {
        logic [55:0] pat;
        logic [3:0]  brd;
        logic        rin;
        logic [6:0]  tin;
        logic [6:0]  tout;
        logic [6:0]  toe;
        logic        gate;
        logic        rout;
        logic        roe;
        logic        cfl;
    } tlx_row_t;

    logic        pclk;
    logic        presetn;
    logic        clk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  brd;
    logic        rin_drv;
    logic [6:0]  tin_drv;
    logic        gate;
    logic        rf_in;
    logic        rf_out;
    logic        rf_oe;
    logic [6:0]  tl_in;
    logic [6:0]  tl_out;
    logic [6:0]  tl_oe;
    logic [31:0] d;
    logic        e;
    int          error_cnt;
    int          comparisons;
    tlx_row_t    rows [7];

    // Shared lines resolve from the switch's enable and the bench's own drive.
    assign tl_in = (tl_oe & tl_out) | (~tl_oe & tin_drv);
    assign rf_in = rf_oe ? rf_out : rin_drv;

    tlx_if tlx_if_inst();

    tlx_host tlx_host_inst
    (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg(tlx_if_inst.host)
    );

    tlx_switch tlx_switch_inst
    (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .cfg(tlx_if_inst.device),
        .timer1_pulse_n(brd[0]), .internal_update_strobe_n(brd[1]), .timer3_pulse_n(brd[2]),
        .timer2_pulse_n(brd[3]), .counter_gate_input(gate), .external_refresh_line_n_in(rf_in),
        .external_refresh_line_n_out(rf_out), .external_refresh_line_n_oe(rf_oe),
        .shared_trigger_line_in(tl_in), .shared_trigger_line_out(tl_out), .shared_trigger_line_oe(tl_oe)
    );

    tlx_checker tlx_checker_inst
    (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .wr_stb(tlx_if_inst.wr_stb),
        .wr_sel(tlx_if_inst.wr_sel), .wr_data(tlx_if_inst.wr_data), .bit_count(tlx_if_inst.bit_count),
        .routing_live(tlx_if_inst.routing_live), .board_conflict(tlx_if_inst.board_conflict)
    );

    always #12.5 pclk = ~pclk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task tally_and_finish;
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One APB transfer; the request is held until the edge that samples pready high.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
             output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task run_row(input tlx_row_t r, input logic pause);
        int n;
        apb(1'b1, `TLX_OFF_PATTERN_LO, r.pat[31:0], d, e);
        apb(1'b1, `TLX_OFF_PATTERN_HI, {8'h00, r.pat[55:32]}, d, e);
        apb(1'b1, `TLX_OFF_CONTROL, 32'h00000001, d, e);
        if (pause)
        begin
            clk_en <= 1'b0;
            repeat (10) @(posedge pclk);
            clk_en <= 1'b1;
        end
        n = 0;
        d = 32'h00000000;
        while (d[1] !== 1'b1 && n < 100)
        begin
            apb(1'b0, `TLX_OFF_STATUS, 32'h00000000, d, e);
            n++;
        end
        check(32'(d[1]), 32'h00000001);
        @(posedge pclk);
        brd     <= r.brd;
        rin_drv <= r.rin;
        tin_drv <= r.tin;
        repeat (4) @(posedge pclk);
        check(32'(tl_oe), 32'(r.toe));
        check(32'(tl_out), 32'(r.tout));
        check(32'(gate), 32'(r.gate));
        check(32'({rf_oe, rf_out}), 32'({r.roe, r.rout}));
        apb(1'b0, `TLX_OFF_STATUS, 32'h00000000, d, e);
        check(d, {14'h0000, r.cfl, 1'b1, 14'h0000, 2'b10});
    endtask

    initial
    begin
        #(25 * 20000);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        pclk = 1'b0; presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h00000000; brd = 4'h0; rin_drv = 1'b0; tin_drv = 7'h00;
        error_cnt = 0; comparisons = 0;
        rows[0] = '{56'h000007000b0000, 4'b0111, 1'b1, 7'h08, 7'h00, 7'h10, 1'b1, 1'b0, 1'b0, 1'b0};
        rows[1] = '{56'h000007000b0000, 4'b1000, 1'b0, 7'h00, 7'h10, 7'h10, 1'b0, 1'b0, 1'b0, 1'b0};
        rows[2] = '{56'h0000005ddddddd, 4'b0000, 1'b1, 7'h00, 7'h7f, 7'h7f, 1'b0, 1'b0, 1'b0, 1'b1};
        rows[3] = '{56'hb0000000000000, 4'b0000, 1'b0, 7'h20, 7'h00, 7'h00, 1'b0, 1'b1, 1'b1, 1'b0};
        rows[4] = '{56'h66666666666666, 4'b1111, 1'b1, 7'h7f, 7'h00, 7'h00, 1'b0, 1'b0, 1'b0, 1'b0};
        rows[5] = '{56'h0000000000b971, 4'b1010, 1'b0, 7'h00, 7'h0a, 7'h0f, 1'b0, 1'b0, 1'b0, 1'b0};
        rows[6] = '{56'h00000000f00000, 4'b1111, 1'b1, 7'h00, 7'h00, 7'h20, 1'b0, 1'b0, 1'b0, 1'b0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
            run_row(rows[i], 1'b0);
        // A clock enable frozen just after the start, before the first shift write, must not corrupt the shifted pattern.
        run_row(rows[5], 1'b1);
        apb(1'b1, 8'h10, 32'hffffffff, d, e);
        check(32'(e), 32'h00000001);
        apb(1'b0, 8'h10, 32'h00000000, d, e);
        check({d[31:1], e}, 32'h00000001);
        apb(1'b1, `TLX_OFF_PATTERN_HI, 32'hffffffff, d, e);
        apb(1'b0, `TLX_OFF_PATTERN_HI, 32'h00000000, d, e);
        check(d, 32'h00ffffff);
        apb(1'b1, `TLX_OFF_PATTERN_LO, 32'ha5a5a5a5, d, e);
        apb(1'b0, `TLX_OFF_PATTERN_LO, 32'h00000000, d, e);
        check(d, 32'ha5a5a5a5);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        check(32'({tl_oe, rf_oe, gate}), 32'h00000000);
        presetn <= 1'b1;
        tin_drv <= 7'h7f;
        rin_drv <= 1'b1;
        repeat (4) @(posedge pclk);
        check(32'({tl_oe, tl_out, rf_oe, gate}), 32'h00000000);
        apb(1'b0, `TLX_OFF_STATUS, 32'h00000000, d, e);
        check(d, 32'h00000000);
        tally_and_finish();
    end
endmodule // test_trigger_line_crosspoint
